// ===== verilog/rtcc_regs.svh
// Register offsets, field positions, reset values and timing counts
//
// Functional notes
// - Control bit 7 switches oscillator and bias currents on or off.
// - Control bit 6 enables the missing-clock detector.
// - Control bit 5 is set on missing clock, cleared by software.
// - Control bit 4 gates the timer; zero holds the count.
// - Control bit 3 enables alarms; clearing it also clears alarm flag.
// - Reading control bit 2 returns the alarm event flag.
// - Writing control bit 2 stores auto-reset enable, flag untouched.
// - Software sets bit 1 to load timer; hardware clears when done.
// - Software sets bit 0 to snapshot timer; hardware clears when done.
// - Alarm flag stays asserted at most one oscillator cycle.
// - Oscillator control bit 7 enables automatic gain control.
// - Oscillator control bit 6: zero self-oscillate, one crystal.
// - Oscillator control bit 5 enables bias doubling.
// - Oscillator control bit 4 reads amplitude-valid indicator.
// - Oscillator control low nibble reads zero, ignores writes.
// - Timer is 32-bit, increments each oscillator cycle while running.
// - Alarm fires on timer equal alarm; auto reset clears next cycle.
// - Detector flags fail when oscillator level holds over 100 us.
// - Load copies snapshot into timer; snapshot copies timer out.
`ifndef RTCC_REGS_SVH
`define RTCC_REGS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define RTCC_IDX_SNAPSHOT     6'h00
`define RTCC_IDX_CONTROL      6'h04
`define RTCC_IDX_OSC_CONTROL  6'h05
`define RTCC_IDX_ALARM        6'h08

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define RTCC_CTL_OSC_EN       7
`define RTCC_CTL_MCD_EN       6
`define RTCC_CTL_FAIL         5
`define RTCC_CTL_RUN          4
`define RTCC_CTL_ALARM_EN     3
`define RTCC_CTL_ALARM        2
`define RTCC_CTL_LOAD         1
`define RTCC_CTL_SNAP         0

// ---------------------------------------------------------------
// Oscillator control fields
// ---------------------------------------------------------------
`define RTCC_XCN_GAIN         7
`define RTCC_XCN_CRYSTAL      6
`define RTCC_XCN_BIAS2        5
`define RTCC_XCN_AMP_VALID    4

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RTCC_CTL_RESET        8'h00
`define RTCC_XCN_RESET        8'h00
`define RTCC_WORD_RESET       32'h0000_0000
`define RTCC_CLK_PERIOD_NS    40
`define RTCC_MCD_TIME_NS      100000
`define RTCC_MCD_CYCLES       \
    ((`RTCC_MCD_TIME_NS + `RTCC_CLK_PERIOD_NS - 1) / `RTCC_CLK_PERIOD_NS)

`endif

// ===== verilog/rtcc_pkg.sv
// Types shared by the real-time clock control block
package rtcc_pkg;

    typedef struct packed {
        logic osc_enable;
        logic missing_clock_detect_enable;
        logic timer_run;
        logic alarm_enable;
        logic autoreset;
        logic timer_load_request;
        logic timer_snapshot_request;
    } rtcc_ctrl_type;

    typedef struct packed {
        logic gain_control_enable;
        logic crystal_mode_select;
        logic bias_double_enable;
    } rtcc_osc_cfg_type;

endpackage : rtcc_pkg

// ===== verilog/rtcc_top.sv
// Real-time clock control, oscillator config, timer and alarm
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "rtcc_regs.svh"

module rtcc_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        osc_clk_in,
    input  wire logic        amplitude_valid_in,
    output logic             osc_enable,
    output logic             gain_control_enable,
    output logic             crystal_mode_select,
    output logic             bias_double_enable,
    output logic             alarm_event
);

    // ---------------------------------------------------------------
    // Pin synchronisers and oscillator edge detect
    // ---------------------------------------------------------------
    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_prev_reg;
    logic amp_meta_reg;
    logic amp_sync_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            amp_meta_reg <= 1'b0;
            amp_sync_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_clk_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
            amp_meta_reg <= amplitude_valid_in;
            amp_sync_reg <= amp_meta_reg;
        end
    end

    // One tick per oscillator cycle, on its rising edge
    logic osc_tick;
    logic osc_change;
    assign osc_tick   = osc_sync_reg & ~osc_prev_reg;
    assign osc_change = osc_sync_reg ^ osc_prev_reg;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    logic [5:0] word_idx;
    logic       addr_ok;
    logic       wr_ctl;
    logic       wr_xcn;
    logic       wr_snap;
    logic       wr_alarm;
    logic       rd_take;

    assign word_idx = avs_address[7:2];
    assign addr_ok  = (avs_address[1:0] == 2'b00);
    assign wr_ctl   = avs_write & addr_ok & avs_byteenable[0]
                      & (word_idx == `RTCC_IDX_CONTROL);
    assign wr_xcn   = avs_write & addr_ok & avs_byteenable[0]
                      & (word_idx == `RTCC_IDX_OSC_CONTROL);
    assign wr_snap  = avs_write & addr_ok
                      & (word_idx == `RTCC_IDX_SNAPSHOT);
    assign wr_alarm = avs_write & addr_ok
                      & (word_idx == `RTCC_IDX_ALARM);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    rtcc_pkg::rtcc_ctrl_type    ctrl_reg;
    rtcc_pkg::rtcc_ctrl_type    ctrl_next;
    rtcc_pkg::rtcc_osc_cfg_type xcfg_reg;
    rtcc_pkg::rtcc_osc_cfg_type xcfg_next;
    logic                       fail_reg;
    logic                       fail_next;
    logic                       alarm_flag_reg;
    logic                       alarm_flag_next;
    logic [31:0]                timer_reg;
    logic [31:0]                timer_next;
    logic [31:0]                snapshot_reg;
    logic [31:0]                snapshot_next;
    logic [31:0]                alarm_value_reg;
    logic [31:0]                alarm_value_next;
    logic [11:0]                mcd_count_reg;
    logic [11:0]                mcd_count_next;
    logic                       rvalid_reg;
    logic                       rvalid_next;
    logic [31:0]                rdata_reg;
    logic [31:0]                rdata_next;
    logic [7:0]                 ctl_view;
    logic [7:0]                 xcn_view;

    localparam logic [11:0] MCD_LIMIT = 12'(`RTCC_MCD_CYCLES);
    // Parked one past the limit: fail is set once, software can clear it
    localparam logic [11:0] MCD_PARK  = MCD_LIMIT + 12'h001;

    // Byte-lane merge for the 32-bit words
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  lanes
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    always_comb begin
        ctl_view = 8'h00;
        ctl_view[`RTCC_CTL_OSC_EN]   = ctrl_reg.osc_enable;
        ctl_view[`RTCC_CTL_MCD_EN]   = ctrl_reg.missing_clock_detect_enable;
        ctl_view[`RTCC_CTL_FAIL]     = fail_reg;
        ctl_view[`RTCC_CTL_RUN]      = ctrl_reg.timer_run;
        ctl_view[`RTCC_CTL_ALARM_EN] = ctrl_reg.alarm_enable;
        ctl_view[`RTCC_CTL_ALARM]    = alarm_flag_reg;
        ctl_view[`RTCC_CTL_LOAD]     = ctrl_reg.timer_load_request;
        ctl_view[`RTCC_CTL_SNAP]     = ctrl_reg.timer_snapshot_request;
        xcn_view = 8'h00;
        xcn_view[`RTCC_XCN_GAIN]      = xcfg_reg.gain_control_enable;
        xcn_view[`RTCC_XCN_CRYSTAL]   = xcfg_reg.crystal_mode_select;
        xcn_view[`RTCC_XCN_BIAS2]     = xcfg_reg.bias_double_enable;
        xcn_view[`RTCC_XCN_AMP_VALID] = amp_sync_reg;
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_next        = ctrl_reg;
        xcfg_next        = xcfg_reg;
        fail_next        = fail_reg;
        alarm_flag_next  = alarm_flag_reg;
        timer_next       = timer_reg;
        snapshot_next    = snapshot_reg;
        alarm_value_next = alarm_value_reg;
        mcd_count_next   = mcd_count_reg;

        // Software writes
        if (wr_ctl) begin
            ctrl_next.osc_enable = avs_writedata[`RTCC_CTL_OSC_EN];
            ctrl_next.missing_clock_detect_enable =
                avs_writedata[`RTCC_CTL_MCD_EN];
            ctrl_next.timer_run  = avs_writedata[`RTCC_CTL_RUN];
            ctrl_next.alarm_enable = avs_writedata[`RTCC_CTL_ALARM_EN];
            ctrl_next.autoreset  = avs_writedata[`RTCC_CTL_ALARM];
            // Writing zero cannot cancel a request in flight
            if (avs_writedata[`RTCC_CTL_LOAD]) begin
                ctrl_next.timer_load_request = 1'b1;
            end
            if (avs_writedata[`RTCC_CTL_SNAP]) begin
                ctrl_next.timer_snapshot_request = 1'b1;
            end
            if (!avs_writedata[`RTCC_CTL_FAIL]) begin
                fail_next = 1'b0;
            end
            if (!avs_writedata[`RTCC_CTL_ALARM_EN]) begin
                alarm_flag_next = 1'b0;
            end
        end
        if (wr_xcn) begin
            xcfg_next.gain_control_enable =
                avs_writedata[`RTCC_XCN_GAIN];
            xcfg_next.crystal_mode_select =
                avs_writedata[`RTCC_XCN_CRYSTAL];
            xcfg_next.bias_double_enable =
                avs_writedata[`RTCC_XCN_BIAS2];
        end
        if (wr_snap) begin
            snapshot_next = lane_merge(snapshot_reg, avs_writedata,
                                       avs_byteenable);
        end
        if (wr_alarm) begin
            alarm_value_next = lane_merge(alarm_value_reg, avs_writedata,
                                          avs_byteenable);
        end

        // Oscillator-paced work, one step per rising oscillator edge
        if (osc_tick) begin
            alarm_flag_next = 1'b0;
            if (alarm_flag_reg && ctrl_reg.autoreset) begin
                timer_next = `RTCC_WORD_RESET;
            end else if (ctrl_reg.timer_run) begin
                timer_next = timer_reg + 32'h0000_0001;
            end
            if (ctrl_reg.timer_snapshot_request) begin
                snapshot_next = timer_reg;
                ctrl_next.timer_snapshot_request = 1'b0;
            end
            if (ctrl_reg.timer_load_request) begin
                timer_next = snapshot_reg;
                ctrl_next.timer_load_request = 1'b0;
            end
            if (ctrl_reg.alarm_enable && !alarm_flag_reg
                && timer_reg == alarm_value_reg) begin
                alarm_flag_next = 1'b1;
            end
            // A request written in this very cycle is kept for next tick
            if (wr_ctl && avs_writedata[`RTCC_CTL_LOAD]) begin
                ctrl_next.timer_load_request = 1'b1;
            end
            if (wr_ctl && avs_writedata[`RTCC_CTL_SNAP]) begin
                ctrl_next.timer_snapshot_request = 1'b1;
            end
            if (wr_ctl && !avs_writedata[`RTCC_CTL_ALARM_EN]) begin
                alarm_flag_next = 1'b0;
            end
        end

        // Missing-clock detector: cycles since last oscillator level change
        if (osc_change || !ctrl_reg.osc_enable
            || !ctrl_reg.missing_clock_detect_enable) begin
            mcd_count_next = 12'h000;
        end else if (mcd_count_reg != MCD_PARK) begin
            mcd_count_next = mcd_count_reg + 12'h001;
        end
        // Set wins over a software clear in the same cycle
        if (mcd_count_reg == MCD_LIMIT) begin
            fail_next = 1'b1;
        end
    end

    // Read path: one wait state, data registered
    always_comb begin
        rvalid_next = avs_read & ~rvalid_reg;
        rdata_next  = rdata_reg;
        rd_take     = avs_read & ~rvalid_reg;
        if (rd_take) begin
            rdata_next = 32'h0000_0000;
            if (addr_ok) begin
                case (word_idx)
                    `RTCC_IDX_SNAPSHOT:    rdata_next = snapshot_reg;
                    `RTCC_IDX_CONTROL:     rdata_next = {24'h000000, ctl_view};
                    `RTCC_IDX_OSC_CONTROL: rdata_next = {24'h000000, xcn_view};
                    `RTCC_IDX_ALARM:       rdata_next = alarm_value_reg;
                    default:               rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg        <= rtcc_pkg::rtcc_ctrl_type'(7'h00);
            xcfg_reg        <= rtcc_pkg::rtcc_osc_cfg_type'(3'h0);
            fail_reg        <= 1'b0;
            alarm_flag_reg  <= 1'b0;
            timer_reg       <= `RTCC_WORD_RESET;
            snapshot_reg    <= `RTCC_WORD_RESET;
            alarm_value_reg <= `RTCC_WORD_RESET;
            mcd_count_reg   <= 12'h000;
            rvalid_reg      <= 1'b0;
            rdata_reg       <= 32'h0000_0000;
        end else begin
            ctrl_reg        <= ctrl_next;
            xcfg_reg        <= xcfg_next;
            fail_reg        <= fail_next;
            alarm_flag_reg  <= alarm_flag_next;
            timer_reg       <= timer_next;
            snapshot_reg    <= snapshot_next;
            alarm_value_reg <= alarm_value_next;
            mcd_count_reg   <= mcd_count_next;
            rvalid_reg      <= rvalid_next;
            rdata_reg       <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign avs_readdata        = rdata_reg;
    assign avs_waitrequest     = avs_read & ~rvalid_reg;
    assign osc_enable          = ctrl_reg.osc_enable;
    assign gain_control_enable = xcfg_reg.gain_control_enable;
    assign crystal_mode_select = xcfg_reg.crystal_mode_select;
    assign bias_double_enable  = xcfg_reg.bias_double_enable;
    assign alarm_event         = alarm_flag_reg;

endmodule : rtcc_top

// ===== tb/rtcc_top_checker.sv
// Port-level assertions for the real-time clock control block
`timescale 1ns/10ps
module rtcc_top_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        osc_clk_in,
    input wire logic        osc_enable,
    input wire logic        gain_control_enable,
    input wire logic        crystal_mode_select,
    input wire logic        bias_double_enable,
    input wire logic        alarm_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic       ctl_wr;
    logic       cfg_wr;
    logic       rd_done;
    logic [2:0] cfg;
    assign ctl_wr = avs_write && avs_address == 8'h10 && avs_byteenable[0];
    assign cfg_wr = avs_write && avs_address == 8'h14 && avs_byteenable[0];
    assign rd_done = avs_read && !avs_waitrequest;
    assign cfg = {gain_control_enable, crystal_mode_select,
                  bias_double_enable};
    // ---------------------------------------------------------------
    // Bus timing
    // ---------------------------------------------------------------
    sequence s_read_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_read_one_wait: assert property ($rose(avs_read) |-> s_read_wait)
        else $error("read answer not after one wait cycle");
    a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    // ---------------------------------------------------------------
    // Register effects
    // ---------------------------------------------------------------
    a_osc_en_write: assert property (
        ctl_wr |=> osc_enable == $past(avs_writedata[7]))
        else $error("oscillator enable does not follow write");
    a_osc_en_hold: assert property (!ctl_wr |=> $stable(osc_enable))
        else $error("oscillator enable changed without write");
    a_cfg_bits_write: assert property (
        cfg_wr |=> cfg == $past(avs_writedata[7:5]))
        else $error("oscillator config does not follow write");
    a_cfg_bits_hold: assert property (
        !cfg_wr |=> $stable(cfg))
        else $error("oscillator config changed without write");
    a_ctl_read_back: assert property (
        rd_done && avs_address == 8'h10 |-> avs_readdata[7] == osc_enable)
        else $error("control read disagrees with oscillator enable");
    a_cfg_read_back: assert property (
        rd_done && avs_address == 8'h14
        |-> avs_readdata[7:5] == cfg && avs_readdata[3:0] == 4'h0)
        else $error("oscillator config read wrong");
    a_unmapped_zero: assert property (
        rd_done && !(avs_address inside {8'h00, 8'h10, 8'h14, 8'h20})
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    // ---------------------------------------------------------------
    // Alarm flag
    // ---------------------------------------------------------------
    sequence s_flag_tick;
        alarm_event && $rose(osc_clk_in);
    endsequence
    a_alarm_short: assert property (
        s_flag_tick |-> ##[1:6] !alarm_event)
        else $error("alarm flag outlived one oscillator cycle");
    a_alarm_clear: assert property (
        ctl_wr && !avs_writedata[3] |=> !alarm_event)
        else $error("alarm disable did not clear flag");
endmodule : rtcc_top_checker

bind rtcc_top rtcc_top_checker chk_u (
    .clk                 (clk),
    .rst                 (rst),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .osc_clk_in          (osc_clk_in),
    .osc_enable          (osc_enable),
    .gain_control_enable (gain_control_enable),
    .crystal_mode_select (crystal_mode_select),
    .bias_double_enable  (bias_double_enable),
    .alarm_event         (alarm_event)
);

// ===== tb/rtc_control_and_osc_config_test.sv
// Self-checking bench for the real-time clock control block
`timescale 1ns/10ps
module rtc_control_and_osc_config_test;
    logic        clk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        osc_clk_in;
    logic        amp_in;
    logic        osc_on;
    logic [2:0]  cfg;
    logic        alarm_event;
    int          bad_count;
    int          comparisons;

    rtcc_top dut_u (
        .clk                 (clk),
        .rst                 (rst),
        .avs_address         (avs_address),
        .avs_read            (avs_read),
        .avs_write           (avs_write),
        .avs_writedata       (avs_writedata),
        .avs_byteenable      (avs_byteenable),
        .avs_readdata        (avs_readdata),
        .avs_waitrequest     (avs_waitrequest),
        .osc_clk_in          (osc_clk_in),
        .amplitude_valid_in  (amp_in),
        .osc_enable          (osc_on),
        .gain_control_enable (cfg[2]),
        .crystal_mode_select (cfg[1]),
        .bias_double_enable  (cfg[0]),
        .alarm_event         (alarm_event)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            n++;
            @(posedge clk);
        end
        q = avs_readdata;
        if (n == 20) bad_count++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask : rdchk
    // Oscillator idles low between ticks, as a stopped clock would
    task automatic ticks(input int n);
        repeat (n) begin
            osc_clk_in <= 1'b1;
            repeat (4) @(posedge clk);
            osc_clk_in <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : ticks
    task automatic wait_alarm();
        int n;
        n = 0;
        while (alarm_event !== 1'b1 && n < 10) begin
            ticks(1);
            n++;
        end
        check("alarm_event", alarm_event, 32'h1);
    endtask : wait_alarm
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rdchk("ctl_reset", 8'h10, 32'h0);
        rdchk("osc_reset", 8'h14, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_osc_cfg();
        amp_in <= 1'b1;
        wr(8'h14, 32'hff);
        rdchk("osc_all", 8'h14, 32'hf0);
        check("cfg_pins", cfg, 32'h7);
        avs_byteenable <= 4'h0;
        wr(8'h14, 32'h0);
        avs_byteenable <= 4'hf;
        rdchk("osc_no_lane", 8'h14, 32'hf0);
        amp_in <= 1'b0;
        wr(8'h14, 32'h4a);
        rdchk("osc_xtal", 8'h14, 32'h40);
        check("cfg_pins", cfg, 32'h2);
        $display("test osc config done");
    endtask : t_osc_cfg
    task automatic t_unmapped();
        wr(8'h0c, 32'hffff_ffff);
        rdchk("unmapped", 8'h0c, 32'h0);
        rdchk("misaligned", 8'h11, 32'h0);
        $display("test unmapped done");
    endtask : t_unmapped
    task automatic t_timer();
        wr(8'h00, 32'h100);
        wr(8'h10, 32'h82);
        check("osc_on", osc_on, 32'h1);
        rdchk("load_pending", 8'h10, 32'h82);
        ticks(1);
        rdchk("load_done", 8'h10, 32'h80);
        wr(8'h10, 32'h90);
        ticks(5);
        wr(8'h10, 32'h81);
        ticks(1);
        rdchk("snap_done", 8'h10, 32'h80);
        rdchk("snap_value", 8'h00, 32'h105);
        ticks(3);
        wr(8'h10, 32'h81);
        ticks(1);
        rdchk("timer_held", 8'h00, 32'h105);
        $display("test timer done");
    endtask : t_timer
    task automatic t_detect();
        wr(8'h10, 32'hc0);
        ticks(1);
        repeat (2300) @(posedge clk);
        rdchk("no_fail_yet", 8'h10, 32'hc0);
        repeat (300) @(posedge clk);
        rdchk("fail_set", 8'h10, 32'he0);
        wr(8'h10, 32'h80);
        rdchk("fail_cleared", 8'h10, 32'h80);
        $display("test detector done");
    endtask : t_detect
    task automatic t_alarm();
        wr(8'h20, 32'h3);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h82);
        ticks(1);
        wr(8'h10, 32'h9c);
        wait_alarm();
        rdchk("flag_read", 8'h10, 32'h9c);
        ticks(1);
        check("flag_drop", alarm_event, 32'h0);
        wr(8'h10, 32'h8d);
        ticks(1);
        rdchk("autoreset", 8'h00, 32'h0);
        rdchk("flag_low", 8'h10, 32'h88);
        wr(8'h10, 32'h98);
        wait_alarm();
        wr(8'h10, 32'h9c);
        check("flag_kept", alarm_event, 32'h1);
        wr(8'h10, 32'h94);
        check("flag_cleared", alarm_event, 32'h0);
        rdchk("alarm_off", 8'h10, 32'h90);
        $display("test alarm done");
    endtask : t_alarm

    initial begin
        rst = 1'b1;
        avs_address = 8'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        osc_clk_in = 1'b0;
        amp_in = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_osc_cfg();
        t_unmapped();
        t_timer();
        t_detect();
        t_alarm();
        conclude();
    end
    // Roughly seven times the expected run
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule : rtc_control_and_osc_config_test
